// file: logic/pfsel_pkg.sv
// constants shared by the port function select block
`default_nettype none
package pfsel_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned OUT_PINS = 4;          // dedicated output pins
  localparam int unsigned IO_PINS  = 4;          // shared i/o group pins
  localparam int unsigned CFG_W    = 4;          // nibble-wide control words

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned PIN_FREQ     = 0;      // pin carrying the frequency output
  localparam int unsigned PIN_UFLOW    = 1;      // pin carrying the timer underflow output
  localparam int unsigned PIN_BUZ      = 2;      // pin carrying the buzzer signal
  localparam int unsigned PIN_BUZ_INV  = 3;      // pin carrying the inverted buzzer
  localparam int unsigned TMR_SEL_BIT  = 3;      // underflow select inside timer config word

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic             SEL_RST      = 1'b0;   // general-purpose function
  localparam logic [CFG_W-1:0] OUT_DATA_RST = 4'h0;
  localparam logic [CFG_W-1:0] IO_DATA_RST  = 4'h0;
  localparam logic [CFG_W-1:0] IO_DIR_RST   = 4'h0;   // all inputs
  localparam logic [CFG_W-1:0] TMR_CFG_RST  = 4'h0;
  localparam logic             TOGGLE_RST   = 1'b0;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 3;       // flops on every pin input

endpackage
`default_nettype wire

// file: logic/pfsel_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pfsel_pin_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_pin,
  output logic      o_level
);

  // ----------------------------------------------------------------
  // sampling chain
  // ----------------------------------------------------------------
  logic [pfsel_pkg::SYNC_STAGES-1:0] stage;

  // shift the pin through the chain; stage 0 feeds stage 1 only
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stage <= '0;
    end else begin
      stage <= {stage[pfsel_pkg::SYNC_STAGES-2:0], i_pin};
    end
  end

  // ----------------------------------------------------------------
  // filtered level
  // ----------------------------------------------------------------
  // accept a change only when second and third stages agree
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      o_level <= stage[2];
    end
  end

endmodule
`default_nettype wire

// file: logic/pfsel_port_function_select.sv
// pin function multiplexer for output pins and the shared i/o group
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - pin 0 shows data bit when frequency select is 0, frequency output when 1.
// - pin 1 shows data bit when underflow select is 0, underflow output when 1.
// - pin 2 shows data bit when buzzer select is 0, buzzer signal when 1.
// - pin 3 shows data bit when inverted select is 0, inverted buzzer when 1.
// - i/o group is general i/o when serial select is 0, serial when 1.
// - a data bit change under a selected special signal may glitch the pin.
// - data bit 1 is held 0 while pin 1 carries the underflow output.
// - underflow output toggles once per timer underflow, halving the underflow rate.
// - underflow select sits at bit three of the timer output config word.
module pfsel_port_function_select (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  // select bits, stored on i_sel_we
  input  wire logic                          i_sel_we,
  input  wire logic                          i_freq_out_select,
  input  wire logic                          i_buzzer_out_select,
  input  wire logic                          i_buzzer_inv_out_select,
  input  wire logic                          i_serial_pin_select,
  // timer output config word, stored on i_tmr_cfg_we
  input  wire logic                          i_tmr_cfg_we,
  input  wire logic [pfsel_pkg::CFG_W-1:0]   i_tmr_cfg_wdata,
  // output data word, stored on i_out_data_we
  input  wire logic                          i_out_data_we,
  input  wire logic [pfsel_pkg::CFG_W-1:0]   i_out_data_wdata,
  // general i/o data and direction, stored on i_io_we
  input  wire logic                          i_io_we,
  input  wire logic [pfsel_pkg::CFG_W-1:0]   i_io_data_wdata,
  input  wire logic [pfsel_pkg::CFG_W-1:0]   i_io_dir_wdata,
  // on-chip special sources
  input  wire logic                          i_frequency_output,
  input  wire logic                          i_timer_underflow_pulse,
  input  wire logic                          i_buzzer_signal,
  input  wire logic [pfsel_pkg::IO_PINS-1:0] i_serial_out,
  input  wire logic [pfsel_pkg::IO_PINS-1:0] i_serial_oe,
  // pins
  output logic [pfsel_pkg::OUT_PINS-1:0]     o_out_pin,
  input  wire logic [pfsel_pkg::IO_PINS-1:0] i_io_pin_group,
  output logic [pfsel_pkg::IO_PINS-1:0]      o_io_pin_group,
  output logic [pfsel_pkg::IO_PINS-1:0]      o_io_pin_group_oe,
  // read-back state
  output logic                               o_freq_out_select,
  output logic                               o_timer_underflow_out_select,
  output logic                               o_buzzer_out_select,
  output logic                               o_buzzer_inv_out_select,
  output logic                               o_serial_pin_select,
  output logic [pfsel_pkg::CFG_W-1:0]        o_tmr_cfg,
  output logic [pfsel_pkg::CFG_W-1:0]        o_out_data,
  output logic [pfsel_pkg::CFG_W-1:0]        o_io_data,
  output logic [pfsel_pkg::CFG_W-1:0]        o_io_dir,
  output logic [pfsel_pkg::IO_PINS-1:0]      o_gpio_in,
  output logic [pfsel_pkg::IO_PINS-1:0]      o_serial_in,
  output logic                               o_timer_underflow_output
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // choose data bit or special signal; special is or-ed with data,
  // so a changing data bit can disturb the selected waveform
  function automatic logic pin_mux(input logic sel, input logic special, input logic data);
    pin_mux = sel ? (special | data) : data;
  endfunction

  // next-state values and filtered pin levels
  logic                                  next_uflow_sel;
  logic [pfsel_pkg::CFG_W-1:0]           next_out_data;
  logic [pfsel_pkg::IO_PINS-1:0]         pin_level;

  // ----------------------------------------------------------------
  // select bits
  // ----------------------------------------------------------------
  // select word written as a group, cleared by reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_freq_out_select       <= pfsel_pkg::SEL_RST;
      o_buzzer_out_select     <= pfsel_pkg::SEL_RST;
      o_buzzer_inv_out_select <= pfsel_pkg::SEL_RST;
      o_serial_pin_select     <= pfsel_pkg::SEL_RST;
    end else if (i_sel_we) begin
      o_freq_out_select       <= i_freq_out_select;
      o_buzzer_out_select     <= i_buzzer_out_select;
      o_buzzer_inv_out_select <= i_buzzer_inv_out_select;
      o_serial_pin_select     <= i_serial_pin_select;
    end
  end

  // timer config word; underflow select is one of its bits
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tmr_cfg <= pfsel_pkg::TMR_CFG_RST;
    end else if (i_tmr_cfg_we) begin
      o_tmr_cfg <= i_tmr_cfg_wdata;
    end
  end

  // underflow select read straight from its config bit
  assign o_timer_underflow_out_select = o_tmr_cfg[pfsel_pkg::TMR_SEL_BIT];

  // select value as it will stand after this cycle's write
  always_comb begin
    next_uflow_sel = o_timer_underflow_out_select;
    if (i_tmr_cfg_we) begin
      next_uflow_sel = i_tmr_cfg_wdata[pfsel_pkg::TMR_SEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // output data word
  // ----------------------------------------------------------------
  // merge write, then force the underflow pin's data bit low if underflow is selected
  always_comb begin
    next_out_data = o_out_data;
    if (i_out_data_we) begin
      next_out_data = i_out_data_wdata;
    end
    if (next_uflow_sel) begin
      next_out_data[pfsel_pkg::PIN_UFLOW] = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_out_data <= pfsel_pkg::OUT_DATA_RST;
    end else begin
      o_out_data <= next_out_data;
    end
  end

  // ----------------------------------------------------------------
  // timer underflow output
  // ----------------------------------------------------------------
  // one toggle per underflow gives half the underflow rate
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_timer_underflow_output <= pfsel_pkg::TOGGLE_RST;
    end else if (i_timer_underflow_pulse) begin
      o_timer_underflow_output <= ~o_timer_underflow_output;
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  // registered pin drive, one clock behind the selected source
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_out_pin <= pfsel_pkg::OUT_DATA_RST;
    end else begin
      o_out_pin[pfsel_pkg::PIN_FREQ] <= pin_mux(o_freq_out_select,
          i_frequency_output, o_out_data[pfsel_pkg::PIN_FREQ]);
      o_out_pin[pfsel_pkg::PIN_UFLOW] <= pin_mux(o_timer_underflow_out_select,
          o_timer_underflow_output, o_out_data[pfsel_pkg::PIN_UFLOW]);
      o_out_pin[pfsel_pkg::PIN_BUZ] <= pin_mux(o_buzzer_out_select,
          i_buzzer_signal, o_out_data[pfsel_pkg::PIN_BUZ]);
      o_out_pin[pfsel_pkg::PIN_BUZ_INV] <= pin_mux(o_buzzer_inv_out_select,
          ~i_buzzer_signal, o_out_data[pfsel_pkg::PIN_BUZ_INV]);
    end
  end

  // ----------------------------------------------------------------
  // general i/o registers
  // ----------------------------------------------------------------
  // data and direction kept even while serial owns the pins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_io_data <= pfsel_pkg::IO_DATA_RST;
      o_io_dir  <= pfsel_pkg::IO_DIR_RST;
    end else if (i_io_we) begin
      o_io_data <= i_io_data_wdata;
      o_io_dir  <= i_io_dir_wdata;
    end
  end

  // ----------------------------------------------------------------
  // i/o group pins
  // ----------------------------------------------------------------
  // drive from general i/o or the serial interface
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_io_pin_group    <= '0;
      o_io_pin_group_oe <= '0;
    end else if (o_serial_pin_select) begin
      o_io_pin_group    <= i_serial_out;
      o_io_pin_group_oe <= i_serial_oe;
    end else begin
      o_io_pin_group    <= o_io_data;
      o_io_pin_group_oe <= o_io_dir;
    end
  end

  // pin inputs pass the three-flop synchroniser
  genvar g;
  generate
    for (g = 0; g < pfsel_pkg::IO_PINS; g++) begin : g_sync
      pfsel_pin_sync u_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      (i_io_pin_group[g]),
        .o_level    (pin_level[g])
      );
    end
  endgenerate

  // route pin levels to general i/o always, and to serial only while it owns the pins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_gpio_in   <= '0;
      o_serial_in <= '0;
    end else begin
      o_gpio_in   <= pin_level;
      o_serial_in <= o_serial_pin_select ? pin_level : '0;
    end
  end

endmodule
`default_nettype wire

// file: verification/pfsel_sva.sv
// assertion checker for the port function select block
`timescale 1ns/1ps
`default_nettype none
module pfsel_sva (
  input wire logic                           i_core_clk,
  input wire logic                           i_rst,
  input wire logic                           i_tmr_cfg_we,
  input wire logic [pfsel_pkg::CFG_W-1:0]    i_tmr_cfg_wdata,
  input wire logic                           i_frequency_output,
  input wire logic                           i_timer_underflow_pulse,
  input wire logic                           i_buzzer_signal,
  input wire logic [pfsel_pkg::IO_PINS-1:0]  i_serial_out,
  input wire logic [pfsel_pkg::IO_PINS-1:0]  i_serial_oe,
  input wire logic [pfsel_pkg::OUT_PINS-1:0] o_out_pin,
  input wire logic [pfsel_pkg::IO_PINS-1:0]  o_io_pin_group,
  input wire logic [pfsel_pkg::IO_PINS-1:0]  o_io_pin_group_oe,
  input wire logic                           o_freq_out_select,
  input wire logic                           o_timer_underflow_out_select,
  input wire logic                           o_buzzer_out_select,
  input wire logic                           o_buzzer_inv_out_select,
  input wire logic                           o_serial_pin_select,
  input wire logic [pfsel_pkg::CFG_W-1:0]    o_tmr_cfg,
  input wire logic [pfsel_pkg::CFG_W-1:0]    o_out_data,
  input wire logic [pfsel_pkg::CFG_W-1:0]    o_io_data,
  input wire logic [pfsel_pkg::CFG_W-1:0]    o_io_dir,
  input wire logic                           o_timer_underflow_output
);
  // ----------------------------------------------------------------
  // pin muxing, one edge after the sources
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_pin0_freq_mux: assert property (!$past(i_rst) |-> o_out_pin[0] ==
    ($past(o_freq_out_select) & $past(i_frequency_output) | $past(o_out_data[0])))
    else $error("pin 0 source wrong");
  a_pin1_uflow_mux: assert property (!$past(i_rst) |-> o_out_pin[1] ==
    ($past(o_timer_underflow_out_select) & $past(o_timer_underflow_output) | $past(o_out_data[1])))
    else $error("pin 1 source wrong");
  a_pin2_buzz_mux: assert property (!$past(i_rst) |-> o_out_pin[2] ==
    ($past(o_buzzer_out_select) & $past(i_buzzer_signal) | $past(o_out_data[2])))
    else $error("pin 2 source wrong");
  a_pin3_inv_mux: assert property (!$past(i_rst) |-> o_out_pin[3] ==
    ($past(o_buzzer_inv_out_select) & ~$past(i_buzzer_signal) | $past(o_out_data[3])))
    else $error("pin 3 source wrong");
  a_io_group_route: assert property (!$past(i_rst) |->
    o_io_pin_group_oe == ($past(o_serial_pin_select) ? $past(i_serial_oe) : $past(o_io_dir)) &&
    o_io_pin_group == ($past(o_serial_pin_select) ? $past(i_serial_out) : $past(o_io_data)))
    else $error("io group source wrong");
  // ----------------------------------------------------------------
  // stored state
  // ----------------------------------------------------------------
  a_data1_held: assert property (o_timer_underflow_out_select |-> !o_out_data[1])
    else $error("data bit 1 not held low");
  a_uflow_toggle: assert property (!$past(i_rst) |->
    $changed(o_timer_underflow_output) == $past(i_timer_underflow_pulse))
    else $error("underflow output toggle wrong");
  a_cfg_sel_bit: assert property (i_tmr_cfg_we |=> o_tmr_cfg == $past(i_tmr_cfg_wdata) &&
    o_timer_underflow_out_select == $past(i_tmr_cfg_wdata[pfsel_pkg::TMR_SEL_BIT]))
    else $error("underflow select bit wrong");
  a_sel_cleared: assert property ($past(i_rst) |-> {o_freq_out_select,
    o_timer_underflow_out_select, o_buzzer_out_select, o_buzzer_inv_out_select,
    o_serial_pin_select} == 5'h00) else $error("selects not cleared");
endmodule
bind pfsel_port_function_select pfsel_sva u_pfsel_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_tmr_cfg_we(i_tmr_cfg_we),
  .i_tmr_cfg_wdata(i_tmr_cfg_wdata), .i_frequency_output(i_frequency_output),
  .i_timer_underflow_pulse(i_timer_underflow_pulse), .i_buzzer_signal(i_buzzer_signal),
  .i_serial_out(i_serial_out), .i_serial_oe(i_serial_oe), .o_out_pin(o_out_pin),
  .o_io_pin_group(o_io_pin_group), .o_io_pin_group_oe(o_io_pin_group_oe),
  .o_freq_out_select(o_freq_out_select),
  .o_timer_underflow_out_select(o_timer_underflow_out_select),
  .o_buzzer_out_select(o_buzzer_out_select),
  .o_buzzer_inv_out_select(o_buzzer_inv_out_select),
  .o_serial_pin_select(o_serial_pin_select), .o_tmr_cfg(o_tmr_cfg),
  .o_out_data(o_out_data), .o_io_data(o_io_data), .o_io_dir(o_io_dir),
  .o_timer_underflow_output(o_timer_underflow_output));
`default_nettype wire

// file: verification/pfsel_sources.sv
// model of the on-chip sources and the far side of the i/o pins
`timescale 1ns/1ps
`default_nettype none
module pfsel_sources (
  input  wire logic       i_core_clk,
  input  wire logic       i_run,
  input  wire logic [3:0] i_drive,
  input  wire logic [3:0] i_drive_oe,
  output logic            o_freq,
  output logic            o_buzz,
  output logic            o_uflow,
  output logic [3:0]      o_ser,
  output logic [3:0]      o_ser_oe,
  output logic [3:0]      o_pins
);
  logic [3:0] cnt = 4'h0;
  // free count while the sources run
  always_ff @(posedge i_core_clk) begin
    if (i_run) begin
      cnt <= cnt + 4'h1;
    end
  end
  // source waveforms and pin levels from all drivers
  assign o_freq   = cnt[0];
  assign o_buzz   = cnt[1];
  assign o_uflow  = i_run & (cnt[2:0] == 3'h5);
  assign o_ser    = 4'h9;
  assign o_ser_oe = 4'hc;
  assign o_pins   = (i_drive_oe & i_drive) | (~i_drive_oe & 4'h6);
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the port function select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic i_core_clk = 1'b0, i_rst = 1'b1, run = 1'b0, tog, have;
  logic i_sel_we = 1'b0, i_freq_out_select = 1'b0, i_buzzer_out_select = 1'b0;
  logic i_buzzer_inv_out_select = 1'b0, i_serial_pin_select = 1'b0;
  logic i_tmr_cfg_we = 1'b0, i_out_data_we = 1'b0, i_io_we = 1'b0;
  logic [3:0] i_tmr_cfg_wdata = 4'h0, i_out_data_wdata = 4'h0, exp;
  logic [3:0] i_io_data_wdata = 4'h0, i_io_dir_wdata = 4'h0;
  wire logic i_frequency_output, i_timer_underflow_pulse, i_buzzer_signal;
  wire logic [3:0] i_serial_out, i_serial_oe, i_io_pin_group;
  logic [3:0] o_out_pin, o_io_pin_group, o_io_pin_group_oe, o_tmr_cfg, o_out_data;
  logic [3:0] o_io_data, o_io_dir, o_gpio_in, o_serial_in;
  logic o_freq_out_select, o_timer_underflow_out_select, o_buzzer_out_select;
  logic o_buzzer_inv_out_select, o_serial_pin_select, o_timer_underflow_output;
  int n_fail = 0, n_checks = 0;
  wire logic [4:0] sels;
  // select bits gathered for compact checks
  assign sels = {o_freq_out_select, o_timer_underflow_out_select, o_buzzer_out_select,
    o_buzzer_inv_out_select, o_serial_pin_select};
  pfsel_port_function_select u_pfsel_port_function_select (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sel_we(i_sel_we),
    .i_freq_out_select(i_freq_out_select), .i_buzzer_out_select(i_buzzer_out_select),
    .i_buzzer_inv_out_select(i_buzzer_inv_out_select),
    .i_serial_pin_select(i_serial_pin_select), .i_tmr_cfg_we(i_tmr_cfg_we),
    .i_tmr_cfg_wdata(i_tmr_cfg_wdata), .i_out_data_we(i_out_data_we),
    .i_out_data_wdata(i_out_data_wdata), .i_io_we(i_io_we),
    .i_io_data_wdata(i_io_data_wdata), .i_io_dir_wdata(i_io_dir_wdata),
    .i_frequency_output(i_frequency_output),
    .i_timer_underflow_pulse(i_timer_underflow_pulse),
    .i_buzzer_signal(i_buzzer_signal), .i_serial_out(i_serial_out),
    .i_serial_oe(i_serial_oe), .o_out_pin(o_out_pin), .i_io_pin_group(i_io_pin_group),
    .o_io_pin_group(o_io_pin_group), .o_io_pin_group_oe(o_io_pin_group_oe),
    .o_freq_out_select(o_freq_out_select),
    .o_timer_underflow_out_select(o_timer_underflow_out_select),
    .o_buzzer_out_select(o_buzzer_out_select),
    .o_buzzer_inv_out_select(o_buzzer_inv_out_select),
    .o_serial_pin_select(o_serial_pin_select), .o_tmr_cfg(o_tmr_cfg),
    .o_out_data(o_out_data), .o_io_data(o_io_data), .o_io_dir(o_io_dir),
    .o_gpio_in(o_gpio_in), .o_serial_in(o_serial_in),
    .o_timer_underflow_output(o_timer_underflow_output));
  pfsel_sources u_pfsel_sources (.i_core_clk(i_core_clk), .i_run(run), .i_drive(o_io_pin_group),
    .i_drive_oe(o_io_pin_group_oe), .o_freq(i_frequency_output), .o_buzz(i_buzzer_signal),
    .o_uflow(i_timer_underflow_pulse), .o_ser(i_serial_out), .o_ser_oe(i_serial_oe),
    .o_pins(i_io_pin_group));
  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // write selects {serial, inv, buzz, freq}, timer config and output data together
  task automatic wr(input logic [3:0] s, input logic [3:0] c, input logic [3:0] d);
    @(negedge i_core_clk);
    {i_serial_pin_select, i_buzzer_inv_out_select, i_buzzer_out_select, i_freq_out_select} = s;
    {i_tmr_cfg_wdata, i_out_data_wdata} = {c, d};
    {i_sel_we, i_tmr_cfg_we, i_out_data_we} = 3'h7;
    @(negedge i_core_clk);
    {i_sel_we, i_tmr_cfg_we, i_out_data_we} = 3'h0;
  endtask
  task automatic sels_clear();
    `CHK("selects", 5'h00, sels)
  endtask
  task automatic t_gpio_out();
    wr(4'h0, 4'h0, 4'ha);
    @(negedge i_core_clk);
    `CHK("out_pin data", 4'ha, o_out_pin)
    `CHK("out data", 4'ha, o_out_data)
  endtask
  task automatic t_specials();
    wr(4'h7, 4'h8, 4'h2);
    `CHK("data bit 1", 1'b0, o_out_data[1])
    `CHK("uflow select", 1'b1, o_timer_underflow_out_select)
    `CHK("tmr cfg set", 4'h8, o_tmr_cfg)
    `CHK("selects set", 5'h1e, sels)
    {run, tog, have} = 3'b100;
    repeat (16) begin
      @(negedge i_core_clk);
      if (have) `CHK("out_pin special", exp, o_out_pin)
      `CHK("uflow output", tog, o_timer_underflow_output)
      exp = {~i_buzzer_signal, i_buzzer_signal, tog, i_frequency_output};
      tog = tog ^ i_timer_underflow_pulse;
      have = 1'b1;
    end
    run = 1'b0;
    wr(4'h0, 4'h0, 4'h0);
  endtask
  task automatic t_io_group();
    @(negedge i_core_clk);
    {i_io_we, i_io_data_wdata, i_io_dir_wdata} = {1'b1, 4'h5, 4'h3};
    @(negedge i_core_clk);
    i_io_we = 1'b0;
    repeat (6) @(negedge i_core_clk);
    `CHK("io oe gpio", 4'h3, o_io_pin_group_oe)
    `CHK("io out gpio", 4'h5, o_io_pin_group)
    `CHK("gpio in", 4'h5, o_gpio_in)
    `CHK("serial in off", 4'h0, o_serial_in)
    `CHK("io data", 4'h5, o_io_data)
    `CHK("io dir", 4'h3, o_io_dir)
    wr(4'h8, 4'h0, 4'h0);
    repeat (6) @(negedge i_core_clk);
    `CHK("io oe serial", 4'hc, o_io_pin_group_oe)
    `CHK("io out serial", 4'h9, o_io_pin_group)
    `CHK("serial in", 4'ha, o_serial_in)
    `CHK("io data kept", 4'h5, o_io_data)
    `CHK("serial select", 5'h01, sels)
  endtask
  task automatic t_mid_reset();
    wr(4'hf, 4'h8, 4'h0);
    i_rst = 1'b1;
    @(negedge i_core_clk);
    i_rst = 1'b0;
    sels_clear();
    `CHK("tmr cfg", 4'h0, o_tmr_cfg)
    `CHK("out pins reset", 4'h0, o_out_pin)
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence after a 16 cycle reset
  initial begin
    repeat (16) @(negedge i_core_clk);
    i_rst = 1'b0;
    @(negedge i_core_clk);
    sels_clear();
    t_gpio_out();
    t_specials();
    t_io_group();
    t_mid_reset();
    close_out();
  end
  // watchdog well beyond the roughly 60 cycles the tests need
  initial begin
    repeat (2000) @(posedge i_core_clk);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
